/* File: logic/sram_link_pkg.sv */
// shared constants and types for the burst sram link
// assumes a 100 MHz host clock; the link clock is derived from it
package sram_link_pkg;
  localparam int DATA_W = 18;
  localparam int BYTE_W = 9;
  localparam int NBYTES = 2;
  localparam int BURST = 4;
  localparam int ADDR_W = 18;
  localparam int IDX_W = 2;
  localparam logic [1:0] WORD0 = 2'h0;
  localparam logic [1:0] WORD1 = 2'h1;
  localparam logic [1:0] WORD2 = 2'h2;
  localparam logic [1:0] WORD3 = 2'h3;
  localparam int NS_PER_US = 1000;
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int K_DIV = 4;
  localparam int LINK_PERIOD_NS = CLOCK_PERIOD_NS * K_DIV;
  localparam int LOCK_TIME_US = 20;
  localparam int LOCK_CYCLES = (LOCK_TIME_US * NS_PER_US
                                + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);
  localparam int IMP_UPDATE_CYCLES = 1024;
  localparam int IMP_W = $clog2(IMP_UPDATE_CYCLES);
  localparam int PLL_STOP_NS = 30;
  localparam int PLL_STOP_CYCLES = (PLL_STOP_NS + CLOCK_PERIOD_NS - 1)
                                   / CLOCK_PERIOD_NS;
  localparam int STOP_W = $clog2(PLL_STOP_CYCLES + 1);
  localparam logic [1:0] PH_PRE_RISE = 2'h0;
  localparam logic [1:0] PH_PRE_FALL = 2'h2;
  localparam logic [1:0] PH_HIGH_END = 2'h3;
  typedef enum logic [1:0] {
    LINK_RUN  = 2'b01,
    LINK_STOP = 2'b10
  } link_state_t;
endpackage

/* File: logic/sram_link_if.sv */
// pins between the memory controller and the burst sram
// the read bus is resolved here from the device's output enable
`timescale 1ns/1ps
interface sram_link_if #(
  parameter int AW = sram_link_pkg::ADDR_W
) ();
  import sram_link_pkg::*;
  logic              k;
  logic              k_n;
  logic              read_port_select_n;
  logic              write_port_select_n;
  logic              pll_disable_n;
  logic [AW-1:0]     addr;
  logic [DATA_W-1:0] d;
  logic [NBYTES-1:0] byte_write_select_n;
  logic [DATA_W-1:0] q;
  logic              q_oe;
  logic              read_valid_indicator;
  logic              echo_clock;
  logic              echo_clock_n;
  wire  [DATA_W-1:0] q_pins;

  // a released bus is shown by q_oe low; the pins then read zero
  assign q_pins = q_oe ? q : '0;

  modport device (
    input  k, k_n, read_port_select_n, write_port_select_n,
    input  pll_disable_n, addr, d, byte_write_select_n,
    output q, q_oe, read_valid_indicator, echo_clock, echo_clock_n
  );
  modport host (
    output k, k_n, read_port_select_n, write_port_select_n,
    output pll_disable_n, addr, d, byte_write_select_n,
    input  q_pins, read_valid_indicator, echo_clock, echo_clock_n
  );
endinterface

/* File: logic/sync_agree.sv */
// three-stage level synchroniser with agreement filter
// assumes i_level is asynchronous to i_clock
`timescale 1ns/1ps
module sync_agree #(
  parameter logic RST = 1'b1
) (
  input  wire logic i_clock,
  input  wire logic i_reset_n,
  input  wire logic i_level,
  output logic      o_level
);
  logic [2:0] sh_r;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sh_r <= {3{RST}};
      o_level <= RST;
    end else begin
      sh_r <= {sh_r[1:0], i_level};
      // a change counts only once stages two and three agree
      if (sh_r[1] == sh_r[2]) begin
        o_level <= sh_r[2];
      end
    end
  end
endmodule

/* File: logic/burst_sram_device.sv */
// device end: burst sram with separate ddr read and write ports
// assumes k and k_n are a complementary pair from the controller;
// k_n rising stands in for the negative input clock edge
//
// Contract
// - read starts on read select low at k
// - pll on: first word 2.5 cycles later
// - pll off: read data one cycle later
// - four words, lowest first, over two cycles
// - back-to-back read request is ignored
// - deselect finishes reads, then tristates outputs
// - write: select, then four words, stored
// - back-to-back write request is ignored
// - idle write port ignores its inputs
// - byte selects mask each written word
// - read after write returns newest data
// - both selected after idle: read wins
// - both selected after read: write wins
// - both selected after write: read wins
// - selects sampled only at k rise
// - ports deselect independently, pending ops finish
// - impedance update every 1024 cycles
// - echo clocks follow k and k_n
// - valid indicator leads read data half cycle
// - pll locks 20 us after stable clock
// - controller may stop clocks 30 ns
// - powers up deselected, outputs high impedance
`timescale 1ns/1ps
module burst_sram_device #(
  parameter int AW = sram_link_pkg::ADDR_W
) (
  sram_link_if.device lnk,
  input  wire logic   i_reset_n,
  output logic        o_pll_locked,
  output logic        o_imp_update
);
  import sram_link_pkg::*;

  localparam int MW = AW + IDX_W;

  logic [DATA_W-1:0] mem [0:(2**MW)-1];
  logic              pll_on;
  logic [LOCK_W-1:0] lock_cnt_r;
  logic              locked_r;
  logic [IMP_W-1:0]  imp_cnt_r;
  logic              imp_upd_r;
  logic              link_ok;
  logic              rd_go;
  logic              wr_go;
  logic [3:0]        rs_r;
  logic [AW-1:0]     ra_r [0:3];
  logic [2:0]        ws_r;
  logic [AW-1:0]     wa_r [0:2];
  logic              nw_v_r;
  logic [MW-1:0]     nw_idx_r;
  logic [DATA_W-1:0] nw_d_r;
  logic [NBYTES-1:0] nw_m_r;
  logic              p_hit;
  logic [MW-1:0]     p_idx;
  logic              n_hit;
  logic [MW-1:0]     n_idx;
  logic [DATA_W-1:0] qp_r;
  logic [DATA_W-1:0] qn_r;
  logic              oep_r;
  logic              oen_r;
  logic              vldp_r;
  logic              vldn_r;

  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old_w,
    input logic [DATA_W-1:0] new_w,
    input logic [NBYTES-1:0] sel_n
  );
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int b = 0; b < NBYTES; b++) begin
      if (!sel_n[b]) begin
        res[b*BYTE_W +: BYTE_W] = new_w[b*BYTE_W +: BYTE_W];
      end
    end
    return res;
  endfunction

  sync_agree #(
    .RST (1'b1)
  ) u_pll_mode (
    .i_clock   (lnk.k),
    .i_reset_n (i_reset_n),
    .i_level   (lnk.pll_disable_n),
    .o_level   (pll_on)
  );

  // with the pll on, requests are refused until it has locked
  always_ff @(posedge lnk.k or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lock_cnt_r <= '0;
      locked_r <= 1'b0;
    end else if (pll_on && !locked_r) begin
      lock_cnt_r <= lock_cnt_r + 1'b1;
      if (lock_cnt_r == LOCK_W'(LOCK_CYCLES - 1)) begin
        locked_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge lnk.k or negedge i_reset_n) begin
    if (!i_reset_n) begin
      imp_cnt_r <= '0;
      imp_upd_r <= 1'b0;
    end else begin
      imp_cnt_r <= imp_cnt_r + 1'b1;
      imp_upd_r <= (imp_cnt_r == IMP_W'(IMP_UPDATE_CYCLES - 1));
    end
  end

  assign link_ok = !pll_on || locked_r;
  // a start last cycle blocks the same port now, so held selects
  // alternate read, write, read
  assign rd_go = !lnk.read_port_select_n && link_ok
                 && !rs_r[0];
  assign wr_go = !lnk.write_port_select_n && link_ok
                 && !ws_r[0] && !rd_go;

  always_ff @(posedge lnk.k or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rs_r <= '0;
      for (int i = 0; i < 4; i++) begin
        ra_r[i] <= '0;
      end
    end else begin
      rs_r <= {rs_r[2:0], rd_go};
      ra_r[0] <= lnk.addr;
      for (int i = 1; i < 4; i++) begin
        ra_r[i] <= ra_r[i-1];
      end
    end
  end

  always_ff @(posedge lnk.k or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ws_r <= '0;
      for (int i = 0; i < 3; i++) begin
        wa_r[i] <= '0;
      end
    end else begin
      ws_r <= {ws_r[1:0], wr_go};
      wa_r[0] <= lnk.addr;
      for (int i = 1; i < 3; i++) begin
        wa_r[i] <= wa_r[i-1];
      end
    end
  end

  // words land in the array one by one, so a following read
  // always finds the newest data without a bypass path
  always_ff @(posedge lnk.k) begin
    if (ws_r[0]) begin
      mem[{wa_r[0], WORD0}] <= merge(mem[{wa_r[0], WORD0}],
                                     lnk.d, lnk.byte_write_select_n);
    end
    if (ws_r[1]) begin
      mem[{wa_r[1], WORD2}] <= merge(mem[{wa_r[1], WORD2}],
                                     lnk.d, lnk.byte_write_select_n);
    end
    if (nw_v_r) begin
      mem[nw_idx_r] <= merge(mem[nw_idx_r], nw_d_r, nw_m_r);
    end
  end

  // negative-edge words are parked here and committed on k
  always_ff @(posedge lnk.k_n or negedge i_reset_n) begin
    if (!i_reset_n) begin
      nw_v_r <= 1'b0;
      nw_idx_r <= '0;
      nw_d_r <= '0;
      nw_m_r <= '1;
    end else begin
      nw_v_r <= ws_r[1] || ws_r[2];
      nw_idx_r <= ws_r[1] ? {wa_r[1], WORD1} : {wa_r[2], WORD3};
      nw_d_r <= lnk.d;
      nw_m_r <= lnk.byte_write_select_n;
    end
  end

  // word slots per edge; rs_r[n] marks a read started n+1 k rises ago
  always_comb begin
    p_hit = 1'b0;
    p_idx = '0;
    n_hit = 1'b0;
    n_idx = '0;
    if (pll_on) begin
      if (rs_r[2]) begin
        p_hit = 1'b1;
        p_idx = {ra_r[2], WORD1};
        n_hit = 1'b1;
        n_idx = {ra_r[2], WORD0};
      end else if (rs_r[3]) begin
        p_hit = 1'b1;
        p_idx = {ra_r[3], WORD3};
        n_hit = 1'b1;
        n_idx = {ra_r[3], WORD2};
      end
    end else begin
      if (rs_r[0]) begin
        p_hit = 1'b1;
        p_idx = {ra_r[0], WORD0};
      end else if (rs_r[1]) begin
        p_hit = 1'b1;
        p_idx = {ra_r[1], WORD2};
      end
      if (rs_r[1]) begin
        n_hit = 1'b1;
        n_idx = {ra_r[1], WORD1};
      end else if (rs_r[2]) begin
        n_hit = 1'b1;
        n_idx = {ra_r[2], WORD3};
      end
    end
  end

  always_ff @(posedge lnk.k or negedge i_reset_n) begin
    if (!i_reset_n) begin
      qp_r <= '0;
      oep_r <= 1'b0;
      vldp_r <= 1'b0;
    end else begin
      qp_r <= p_hit ? mem[p_idx] : '0;
      oep_r <= p_hit;
      vldp_r <= pll_on ? (rs_r[1] || rs_r[2])
                       : (rs_r[0] || rs_r[1]);
    end
  end

  always_ff @(posedge lnk.k_n or negedge i_reset_n) begin
    if (!i_reset_n) begin
      qn_r <= '0;
      oen_r <= 1'b0;
      vldn_r <= 1'b0;
    end else begin
      qn_r <= n_hit ? mem[n_idx] : '0;
      oen_r <= n_hit;
      vldn_r <= pll_on ? (rs_r[2] || rs_r[3])
                       : (rs_r[0] || rs_r[1]);
    end
  end

  // ddr output mux: each half cycle shows its own edge's register
  assign lnk.q = lnk.k ? qp_r : qn_r;
  assign lnk.q_oe = lnk.k ? oep_r : oen_r;
  assign lnk.read_valid_indicator = lnk.k ? vldp_r : vldn_r;
  assign lnk.echo_clock = lnk.k;
  assign lnk.echo_clock_n = lnk.k_n;

  assign o_pll_locked = locked_r;
  assign o_imp_update = imp_upd_r;
endmodule

/* File: logic/burst_sram_host.sv */
// controller end: makes the link clocks and runs read/write bursts
// assumes the user holds a request until its ack pulse
`timescale 1ns/1ps
module burst_sram_host #(
  parameter int AW = sram_link_pkg::ADDR_W
) (
  sram_link_if.host                                     lnk,
  input  wire logic                                     i_clock,
  input  wire logic                                     i_reset_n,
  input  wire logic                                     i_rd_req,
  input  wire logic [AW-1:0]                            i_rd_addr,
  input  wire logic                                     i_wr_req,
  input  wire logic [AW-1:0]                            i_wr_addr,
  input  wire logic [sram_link_pkg::BURST*sram_link_pkg::DATA_W-1:0]
                                                        i_wr_data,
  input  wire logic [sram_link_pkg::BURST*sram_link_pkg::NBYTES-1:0]
                                                        i_wr_mask_n,
  input  wire logic                                     i_pll_disable_n,
  input  wire logic                                     i_pll_reset,
  output logic                                          o_rd_ack,
  output logic                                          o_wr_ack,
  output logic                                          o_rd_valid,
  output logic [sram_link_pkg::BURST*sram_link_pkg::DATA_W-1:0]
                                                        o_rd_data
);
  import sram_link_pkg::*;

  localparam int BW = BURST * DATA_W;
  localparam int MB = BURST * NBYTES;

  link_state_t       state_r;
  logic [STOP_W-1:0] stop_cnt_r;
  logic [1:0]        ph_r;
  logic [1:0]        ph_nxt;
  logic              tick;
  logic              rise_tick;
  logic              rd_go;
  logic              wr_go;
  logic              rd_last_r;
  logic              wr_last_r;
  logic [4:0]        wpipe_r;
  logic [BW-1:0]     wbuf_r;
  logic [MB-1:0]     mbuf_r;
  logic [BW-1:0]     dsh_r;
  logic [MB-1:0]     msh_r;
  logic              vld_seen_r;
  logic [1:0]        rcnt_r;
  logic [BW-1:0]     rsh_r;
  logic [BW-1:0]     rdata_r;
  logic              rvalid_r;
  logic              rd_ack_r;
  logic              wr_ack_r;
  logic              k_r;
  logic              kn_r;
  logic              rps_n_r;
  logic              wps_n_r;
  logic              pll_dis_r;
  logic [AW-1:0]     addr_r;
  logic [DATA_W-1:0] d_r;
  logic [NBYTES-1:0] bws_n_r;

  assign ph_nxt = ph_r + 1'b1;
  // select, address and data outputs change midway between link edges, never on one
  assign tick = (state_r == LINK_RUN) && !ph_r[0];
  assign rise_tick = tick && (ph_r == PH_PRE_RISE);
  assign rd_go = rise_tick && i_rd_req && !rd_last_r;
  assign wr_go = rise_tick && i_wr_req && !wr_last_r
                 && !rd_go;

  // link clock by division; a pll reset parks both clocks high
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= LINK_RUN;
      stop_cnt_r <= '0;
      ph_r <= PH_HIGH_END;
      k_r <= 1'b1;
      kn_r <= 1'b0;
    end else begin
      unique case (state_r)
        LINK_RUN: begin
          if (i_pll_reset && ph_r == PH_HIGH_END && wpipe_r == '0) begin
            state_r <= LINK_STOP;
            stop_cnt_r <= '0;
            kn_r <= 1'b1;
          end else begin
            ph_r <= ph_nxt;
            k_r <= ph_nxt[1];
            kn_r <= !ph_nxt[1];
          end
        end
        LINK_STOP: begin
          stop_cnt_r <= stop_cnt_r + 1'b1;
          if (stop_cnt_r == STOP_W'(PLL_STOP_CYCLES - 1)) begin
            state_r <= LINK_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rps_n_r <= 1'b1;
      wps_n_r <= 1'b1;
      addr_r <= '0;
      rd_last_r <= 1'b0;
      wr_last_r <= 1'b0;
      rd_ack_r <= 1'b0;
      wr_ack_r <= 1'b0;
      wbuf_r <= '0;
      mbuf_r <= '1;
      pll_dis_r <= 1'b1;
    end else begin
      pll_dis_r <= i_pll_disable_n;
      rd_ack_r <= rd_go;
      wr_ack_r <= wr_go;
      if (tick) begin
        rps_n_r <= !rd_go;
        wps_n_r <= !wr_go;
      end
      if (rise_tick) begin
        rd_last_r <= rd_go;
        wr_last_r <= wr_go;
        addr_r <= rd_go ? i_rd_addr : i_wr_addr;
      end
      if (wr_go) begin
        wbuf_r <= i_wr_data;
        mbuf_r <= i_wr_mask_n;
      end
    end
  end

  // wpipe_r[n] marks a write issued n+1 half cycles ago
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wpipe_r <= '0;
      dsh_r <= '0;
      msh_r <= '1;
      d_r <= '0;
      bws_n_r <= '1;
    end else if (tick) begin
      wpipe_r <= {wpipe_r[3:0], wr_go};
      if (wpipe_r[0]) begin
        dsh_r <= wbuf_r;
        msh_r <= mbuf_r;
      end else begin
        dsh_r <= dsh_r >> DATA_W;
        msh_r <= msh_r >> NBYTES;
      end
      if (wpipe_r[4:1] != '0) begin
        d_r <= dsh_r[DATA_W-1:0];
        bws_n_r <= msh_r[NBYTES-1:0];
      end else begin
        d_r <= '0;
        bws_n_r <= '1;
      end
    end
  end

  // valid seen on one tick means a word on the next; latency free
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      vld_seen_r <= 1'b0;
      rcnt_r <= '0;
      rsh_r <= '0;
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= 1'b0;
      if (tick) begin
        vld_seen_r <= lnk.read_valid_indicator;
        if (vld_seen_r) begin
          rsh_r <= {lnk.q_pins, rsh_r[BW-1:DATA_W]};
          rcnt_r <= rcnt_r + 1'b1;
          if (rcnt_r == WORD3) begin
            rdata_r <= {lnk.q_pins, rsh_r[BW-1:DATA_W]};
            rvalid_r <= 1'b1;
          end
        end
      end
    end
  end

  assign lnk.k = k_r;
  assign lnk.k_n = kn_r;
  assign lnk.read_port_select_n = rps_n_r;
  assign lnk.write_port_select_n = wps_n_r;
  assign lnk.pll_disable_n = pll_dis_r;
  assign lnk.addr = addr_r;
  assign lnk.d = d_r;
  assign lnk.byte_write_select_n = bws_n_r;
  assign o_rd_ack = rd_ack_r;
  assign o_wr_ack = wr_ack_r;
  assign o_rd_valid = rvalid_r;
  assign o_rd_data = rdata_r;
endmodule

/* File: test/sram_link_chk.sv */
// pin-level assertions for the sram link between host and device
// assumes instantiation beside the link interface, reset shared
`timescale 1ns/1ps
module sram_link_chk
  import sram_link_pkg::*;
(
  input wire logic              k,
  input wire logic              k_n,
  input wire logic              i_reset_n,
  input wire logic              read_port_select_n,
  input wire logic              write_port_select_n,
  input wire logic [NBYTES-1:0] byte_write_select_n,
  input wire logic              q_oe,
  input wire logic              read_valid_indicator,
  input wire logic              echo_clock,
  input wire logic              echo_clock_n
);
  default clocking cb @(posedge k); endclocking
  default disable iff (!i_reset_n);

  property p_echo;
    (echo_clock == k) && (echo_clock_n == k_n);
  endproperty
  a_echo: assert property (p_echo)
    else $error("echo clocks differ from input clocks");

  property p_rd_gap;
    !read_port_select_n |=> read_port_select_n;
  endproperty
  a_rd_gap: assert property (p_rd_gap)
    else $error("read select low on two k rises");

  property p_wr_gap;
    !write_port_select_n |=> write_port_select_n;
  endproperty
  a_wr_gap: assert property (p_wr_gap)
    else $error("write select low on two k rises");

  property p_pwrup;
    $rose(i_reset_n) |-> !q_oe && !read_valid_indicator;
  endproperty
  a_pwrup: assert property (p_pwrup)
    else $error("read bus driven right after reset");

  // six idle k rises cover the longest burst plus the tristate edge
  property p_rd_idle;
    read_port_select_n [*6] |-> !q_oe;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read bus still driven after deselect");

  property p_wr_idle;
    write_port_select_n [*4] |-> &byte_write_select_n;
  endproperty
  a_wr_idle: assert property (p_wr_idle)
    else $error("byte selects active with no write");

  // one k rise back in legacy mode, three with the pll on
  property p_vld_src;
    $rose(read_valid_indicator) |->
      !$past(read_port_select_n) || !$past(read_port_select_n, 3);
  endproperty
  a_vld_src: assert property (p_vld_src)
    else $error("valid indicator without a read start");

  property p_vld_lead;
    $rose(q_oe) |-> read_valid_indicator;
  endproperty
  a_vld_lead: assert property (p_vld_lead)
    else $error("read data without leading valid");
endmodule

/* File: test/tb_top.sv */
// self-checking bench: host and device joined over the link interface
// assumes the design files and sram_link_chk are compiled first
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
  mismatches++; $display("[ERR] t=%0t got %0h exp %0h", $time, a, e); \
  end end
module tb_top;
  import sram_link_pkg::*;
  localparam int AW = 8;
  localparam int DW = BURST * DATA_W;
  localparam logic [DW-1:0] D1 = 72'hA1B2C3D4E5F6071829;
  localparam logic [DW-1:0] D2 = 72'h5E4D3C2B1A09F8E7D6;
  localparam logic [DW-1:0] D3 = 72'h13579BDF02468ACE11;
  logic                    i_clock = 1'b0;
  logic                    i_reset_n;
  logic                    i_rd_req;
  logic [AW-1:0]           i_rd_addr;
  logic                    i_wr_req;
  logic [AW-1:0]           i_wr_addr;
  logic [DW-1:0]           i_wr_data;
  logic [BURST*NBYTES-1:0] i_wr_mask_n;
  logic                    i_pll_disable_n;
  logic                    i_pll_reset;
  logic                    o_rd_ack;
  logic                    o_wr_ack;
  logic                    o_rd_valid;
  logic [DW-1:0]           o_rd_data;
  logic                    o_pll_locked;
  logic                    o_imp_update;
  logic [DW-1:0]           got;
  logic [DW-1:0]           exp5;
  int                      lat;
  int                      mismatches = 0;
  int                      check_count = 0;

  always #5 i_clock = ~i_clock;

  sram_link_if #(.AW(AW)) lnk ();
  burst_sram_host #(.AW(AW)) burst_sram_host_i (
    .lnk(lnk.host), .i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_rd_req(i_rd_req), .i_rd_addr(i_rd_addr), .i_wr_req(i_wr_req),
    .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data),
    .i_wr_mask_n(i_wr_mask_n), .i_pll_disable_n(i_pll_disable_n),
    .i_pll_reset(i_pll_reset), .o_rd_ack(o_rd_ack), .o_wr_ack(o_wr_ack),
    .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data));
  burst_sram_device #(.AW(AW)) burst_sram_device_i (
    .lnk(lnk.device), .i_reset_n(i_reset_n),
    .o_pll_locked(o_pll_locked), .o_imp_update(o_imp_update));
  sram_link_chk sram_link_chk_i (
    .k(lnk.k), .k_n(lnk.k_n), .i_reset_n(i_reset_n),
    .read_port_select_n(lnk.read_port_select_n),
    .write_port_select_n(lnk.write_port_select_n),
    .byte_write_select_n(lnk.byte_write_select_n), .q_oe(lnk.q_oe),
    .read_valid_indicator(lnk.read_valid_indicator),
    .echo_clock(lnk.echo_clock), .echo_clock_n(lnk.echo_clock_n));

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] o,
    input logic [DW-1:0] n, input logic [7:0] m);
    logic [DW-1:0] r;
    r = o;
    for (int i = 0; i < BURST*NBYTES; i++) begin
      if (!m[i]) r[i*BYTE_W +: BYTE_W] = n[i*BYTE_W +: BYTE_W];
    end
    return r;
  endfunction

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] dat,
                    input logic [7:0] m);
    int n;
    i_wr_addr = a;
    i_wr_data = dat;
    i_wr_mask_n = m;
    i_wr_req = 1'b1;
    n = 0;
    do begin @(negedge i_clock); n++; end
    while (o_wr_ack !== 1'b1 && n < 100);
    `CHK(o_wr_ack, 1'b1)
    i_wr_req = 1'b0;
  endtask

  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] dat,
                    output int lt);
    int n;
    i_rd_addr = a;
    i_rd_req = 1'b1;
    n = 0;
    do begin @(negedge i_clock); n++; end
    while (o_rd_ack !== 1'b1 && n < 100);
    `CHK(o_rd_ack, 1'b1)
    i_rd_req = 1'b0;
    lt = 0;
    do begin @(negedge i_clock); lt++; end
    while (o_rd_valid !== 1'b1 && lt < 60);
    dat = o_rd_data;
  endtask

  task automatic t_lock;
    int n;
    n = 0;
    `CHK(lnk.q_oe, 1'b0)
    `CHK(lnk.read_valid_indicator, 1'b0)
    while (o_pll_locked !== 1'b1 && n < 3000) begin
      @(negedge i_clock);
      n++;
    end
    `CHK(n >= (LOCK_CYCLES-1)*K_DIV, 1'b1)
    `CHK(n <= (LOCK_CYCLES+10)*K_DIV, 1'b1)
  endtask

  task automatic t_basic;
    wr(8'h05, D1, 8'h00);
    rd(8'h05, got, lat);
    `CHK(got, D1)
    // word3 four link cycles on; the next tick both takes and flags it
    `CHK(lat, 4*K_DIV + 2)
    wr(8'h05, D2, 8'h96);
    exp5 = merge(D1, D2, 8'h96);
    rd(8'h05, got, lat);
    `CHK(got, exp5)
  endtask

  // read issued the k cycle right after the write to the same place
  task automatic t_fwd;
    wr(8'h09, D3, 8'h00);
    rd(8'h09, got, lat);
    `CHK(got, D3)
  endtask

  task automatic t_both;
    logic [1:0] seq [3];
    int n;
    i_rd_addr = 8'h05;
    i_wr_addr = 8'h0C;
    i_wr_data = D1;
    i_wr_mask_n = 8'h00;
    i_rd_req = 1'b1;
    i_wr_req = 1'b1;
    for (int j = 0; j < 3; j++) begin
      n = 0;
      do begin @(negedge i_clock); n++; end
      while (o_rd_ack !== 1'b1 && o_wr_ack !== 1'b1 && n < 100);
      seq[j] = {o_rd_ack, o_wr_ack};
      if (o_wr_ack === 1'b1) i_wr_req = 1'b0;
    end
    i_rd_req = 1'b0;
    `CHK(seq[0], 2'b10)
    `CHK(seq[1], 2'b01)
    `CHK(seq[2], 2'b10)
    n = 0;
    for (int j = 0; j < 2 && n < 100; n++) begin
      @(negedge i_clock);
      if (o_rd_valid === 1'b1) j++;
    end
    `CHK(o_rd_data, exp5)
    rd(8'h0C, got, lat);
    `CHK(got, D1)
  endtask

  task automatic t_imp;
    int n;
    n = 0;
    while (o_imp_update !== 1'b1 && n < 1100) begin
      @(posedge lnk.k) #1;
      n++;
    end
    n = 0;
    do begin @(posedge lnk.k) #1; n++; end
    while (o_imp_update !== 1'b1 && n < 1100);
    `CHK(n, IMP_UPDATE_CYCLES)
    @(negedge i_clock);
  endtask

  task automatic t_stop;
    int n;
    i_pll_reset = 1'b1;
    n = 0;
    while ((lnk.k & lnk.k_n) !== 1'b1 && n < 40) begin
      @(negedge i_clock);
      n++;
    end
    i_pll_reset = 1'b0;
    n = 0;
    while ((lnk.k & lnk.k_n) === 1'b1 && n < 40) begin
      @(negedge i_clock);
      n++;
    end
    `CHK(n >= PLL_STOP_CYCLES - 1, 1'b1)
    rd(8'h05, got, lat);
    `CHK(got, exp5)
  endtask

  // legacy mode needs a few k rises for the mode input to settle
  task automatic t_off;
    i_pll_disable_n = 1'b0;
    repeat (40) @(negedge i_clock);
    wr(8'h14, D2, 8'h00);
    rd(8'h14, got, lat);
    `CHK(got, D2)
    // word3 at the k_n rise two link cycles on, then tick and flag
    `CHK(lat, 2*K_DIV + K_DIV/2 + 2)
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    i_reset_n = 1'b0;
    i_rd_req = 1'b0;
    i_rd_addr = '0;
    i_wr_req = 1'b0;
    i_wr_addr = '0;
    i_wr_data = '0;
    i_wr_mask_n = '1;
    i_pll_disable_n = 1'b1;
    i_pll_reset = 1'b0;
    repeat (6) @(negedge i_clock);
    i_reset_n = 1'b1;
    t_lock();
    t_basic();
    t_fwd();
    t_both();
    t_imp();
    t_stop();
    t_off();
    tally_and_finish();
  end

  // lock plus two impedance periods stay well below this span
  initial begin
    #300000;
    mismatches++;
    tally_and_finish();
  end
endmodule
